// ---- tcc_defs.svh ----
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Register index and byte address (index 0x16 is not a multiple of four)
`define TCC_CTRL_INDEX       8'h16
`define TCC_CTRL_ADDR        8'h58
`define TCC_STATUS_INDEX     8'h17
`define TCC_STATUS_ADDR      8'h5c
`define TCC_CTRL_RESET       8'h00
// Field positions
`define TCC_CAP2_HI          7
`define TCC_CAP2_LO          6
`define TCC_CAP1_HI          5
`define TCC_CAP1_LO          4
`define TCC_CASCADE_BIT      3
`define TCC_T3_SRC_BIT       2
`define TCC_T2_SRC_BIT       1
`define TCC_T1_SRC_BIT       0
// Internal clock divide
`define TCC_INT_DIV          4
`define TCC_INT_DIV_LAST     2'h3
`endif

// ---- tcc_pkg.sv ----
package tcc_pkg;
  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_RISE4,
    EDGE_RISE16
  } edge_mode_e;

  typedef struct packed {
    edge_mode_e capture2_edge_select;
    edge_mode_e capture1_edge_select;
    logic       cascade_select;
    logic       timer3_source_select;
    logic       timer2_source_select;
    logic       timer1_source_select;
  } ctrl_s;

  typedef struct packed {
    logic timer1_tick;
    logic timer2_tick;
    logic timer3_tick;
    logic capture1_event;
    logic capture2_event;
  } ticks_s;
endpackage

// ---- tcc_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser with edge detect on the settled copy
module tcc_pin_sync
(
  input  wire logic clk_i,   // System clock
  input  wire logic rst_i,   // Sync reset
  input  wire logic pin_i,   // Raw pin
  output logic      rise_o,  // Rising edge pulse
  output logic      fall_o   // Falling edge pulse
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic [1:0] fill_ff;

  // First flop feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // Warm-up count; reset zeros in the flops are not pin levels, so no edge until both hold real samples
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fill_ff <= 2'h0;
    else if (fill_ff != 2'h3)
      fill_ff <= fill_ff + 2'h1;
  end

  // Edge pulses from the settled pair
  assign rise_o = (fill_ff == 2'h3) & sync_ff & ~last_ff;
  assign fall_o = (fill_ff == 2'h3) & ~sync_ff & last_ff;
endmodule
`default_nettype wire

// ---- tcc_capture_prescale.sv ----
`timescale 1ns/100ps
`default_nettype none
// Turns pin edges into capture events per the edge mode
module tcc_capture_prescale
(
  input  wire logic               clk_i,   // System clock
  input  wire logic               rst_i,   // Sync reset
  input  wire tcc_pkg::edge_mode_e mode_i,  // Edge mode
  input  wire logic               rise_i,  // Synced rising edge
  input  wire logic               fall_i,  // Synced falling edge
  output logic                    event_o  // Capture strobe
);
  logic [3:0] count_ff;

  // Rising-edge prescale counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= 4'h0;
    else if (rise_i)
      count_ff <= count_ff + 4'h1;
  end

  // Mode decode
  always_comb
  begin
    case (mode_i)
      tcc_pkg::EDGE_FALL:   event_o = fall_i;
      tcc_pkg::EDGE_RISE:   event_o = rise_i;
      tcc_pkg::EDGE_RISE4:  event_o = rise_i & (count_ff[1:0] == 2'h3);
      tcc_pkg::EDGE_RISE16: event_o = rise_i & (count_ff == 4'hf);
      default:              event_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- timer_capture_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defs.svh"

module timer_capture_control
(
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Sync reset, active high
  input  wire logic        cyc_i,        // Wishbone cycle
  input  wire logic        stb_i,        // Wishbone strobe
  input  wire logic        we_i,         // Wishbone write enable
  input  wire logic [7:0]  adr_i,        // Wishbone byte address
  input  wire logic [3:0]  sel_i,        // Wishbone byte selects
  input  wire logic [31:0] dat_i,        // Wishbone write data
  output logic      [31:0] dat_o,        // Wishbone read data
  output logic             ack_o,        // Wishbone acknowledge
  input  wire logic        timer3_ext_clock_pin_i, // Timer3 external clock
  input  wire logic        shared_ext_clock_pin_i, // Timer1/2 external clock
  input  wire logic        capture1_pin_i,         // Capture1 input
  input  wire logic        capture2_pin_i,         // Capture2 input
  input  wire logic        timer2_run_i,           // Timer2 run bit
  input  wire logic [15:0] timer3_value_i,         // Live timer3 count
  output logic             timer1_tick_o,          // Timer1 increment
  output logic             timer2_tick_o,          // Timer2 increment
  output logic             timer3_tick_o,          // Timer3 increment
  output logic             cascade_o,              // 16-bit mode
  output logic             capture1_strobe_o,      // Capture1 load
  output logic             capture2_strobe_o,      // Capture2 load
  output logic      [15:0] capture1_value_o,       // Capture1 value
  output logic      [15:0] capture2_value_o        // Capture2 value
);
  tcc_pkg::ctrl_s ctrl_ff;
  logic [1:0]     div_ff;
  logic           int_tick;
  logic           t3_rise;
  logic           t3_fall;
  logic           sh_rise;
  logic           sh_fall;
  logic           c1_rise;
  logic           c1_fall;
  logic           c2_rise;
  logic           c2_fall;
  logic           c1_event;
  logic           c2_event;
  logic           t1_src;
  logic           t2_src;
  logic           t1_carry;
  logic           bus_req;
  logic           hit_ctrl;
  logic           hit_status;
  logic [31:0]    nxt_dat;

  // Pin synchronisers
  tcc_pin_sync u_sync_t3 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(timer3_ext_clock_pin_i),
                          .rise_o(t3_rise), .fall_o(t3_fall));
  tcc_pin_sync u_sync_sh (.clk_i(clk_i), .rst_i(rst_i), .pin_i(shared_ext_clock_pin_i),
                          .rise_o(sh_rise), .fall_o(sh_fall));
  tcc_pin_sync u_sync_c1 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(capture1_pin_i),
                          .rise_o(c1_rise), .fall_o(c1_fall));
  tcc_pin_sync u_sync_c2 (.clk_i(clk_i), .rst_i(rst_i), .pin_i(capture2_pin_i),
                          .rise_o(c2_rise), .fall_o(c2_fall));

  // Capture edge prescalers
  tcc_capture_prescale u_pre_c1
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .mode_i  (ctrl_ff.capture1_edge_select),
    .rise_i  (c1_rise),
    .fall_i  (c1_fall),
    .event_o (c1_event)
  );
  tcc_capture_prescale u_pre_c2
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .mode_i  (ctrl_ff.capture2_edge_select),
    .rise_i  (c2_rise),
    .fall_i  (c2_fall),
    .event_o (c2_event)
  );

  // Bus decode
  assign bus_req    = cyc_i & stb_i & ~ack_o;
  assign hit_ctrl   = (adr_i == `TCC_CTRL_ADDR);
  assign hit_status = (adr_i == `TCC_STATUS_ADDR);

  // Control register write, low byte lane only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_ff <= tcc_pkg::ctrl_s'(`TCC_CTRL_RESET);
    else if (bus_req && we_i && hit_ctrl && sel_i[0])
      ctrl_ff <= tcc_pkg::ctrl_s'(dat_i[7:0]);
  end

  // Read mux; unmapped reads return zero
  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    if (hit_ctrl)
      nxt_dat = {24'h00_0000, ctrl_ff};
    else if (hit_status)
      nxt_dat = {29'h0000_0000, cascade_o & ~timer2_run_i, ctrl_ff.cascade_select, timer2_run_i};
  end

  // One-wait-state acknowledge and registered data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= bus_req ? nxt_dat : 32'h0000_0000;
    end
  end

  // Internal clock divider, one tick per four system clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_ff <= 2'h0;
    else
      div_ff <= div_ff + 2'h1;
  end
  assign int_tick = (div_ff == `TCC_INT_DIV_LAST);

  // Source selects
  assign t1_src   = ctrl_ff.timer1_source_select ? sh_fall : int_tick;
  assign t2_src   = ctrl_ff.timer2_source_select ? sh_fall : int_tick;
  // Carry from the lower byte source in cascade mode
  assign t1_carry = t1_src;

  // Timer tick outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer1_tick_o <= 1'b0;
      timer2_tick_o <= 1'b0;
      timer3_tick_o <= 1'b0;
      cascade_o     <= 1'b0;
    end
    else
    begin
      timer1_tick_o <= t1_src;
      timer2_tick_o <= ctrl_ff.cascade_select ? t1_carry : t2_src;
      timer3_tick_o <= ctrl_ff.timer3_source_select ? t3_fall : int_tick;
      cascade_o     <= ctrl_ff.cascade_select;
    end
  end

  // Capture of live timer3 value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capture1_strobe_o <= 1'b0;
      capture2_strobe_o <= 1'b0;
      capture1_value_o  <= 16'h0000;
      capture2_value_o  <= 16'h0000;
    end
    else
    begin
      capture1_strobe_o <= c1_event;
      capture2_strobe_o <= c2_event;
      if (c1_event)
        capture1_value_o <= timer3_value_i;
      if (c2_event)
        capture2_value_o <= timer3_value_i;
    end
  end
endmodule
`default_nettype wire

// ---- timer_capture_control_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// Bus handshake, pulse widths and capture value checks
module tcc_checker
(
  input  wire logic        clk_i,             // Clock
  input  wire logic        rst_i,             // Reset
  input  wire logic        cyc_i,             // Cycle
  input  wire logic        stb_i,             // Strobe
  input  wire logic        we_i,              // Write
  input  wire logic        ack_o,             // Ack
  input  wire logic [31:0] dat_o,             // Read data
  input  wire logic        cascade_o,         // 16-bit mode
  input  wire logic        timer1_tick_o,     // T1 tick
  input  wire logic        timer2_tick_o,     // T2 tick
  input  wire logic        capture2_strobe_o, // Cap2 load
  input  wire logic [15:0] capture2_value_o,  // Cap2 value
  input  wire logic        timer3_tick_o,     // T3 tick
  input  wire logic        capture1_strobe_o, // Cap1 load
  input  wire logic [15:0] capture1_value_o,  // Cap1 value
  input  wire logic [15:0] timer3_value_i     // Timer3 count
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request not yet answered
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  ack_next_a: assert property (req_s |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
  cas_write_a: assert property ($changed(cascade_o) |-> $past(we_i) || $past(we_i, 2))
    else $error("cascade moved without write");
  t1_pulse_a: assert property (timer1_tick_o |=> !timer1_tick_o) else $error("t1 tick held");
  t3_pulse_a: assert property (timer3_tick_o |=> !timer3_tick_o) else $error("t3 tick held");
  cap_pulse_a: assert property (capture1_strobe_o |=> !capture1_strobe_o) else $error("cap held");
  cap_value_a: assert property (capture1_strobe_o |-> capture1_value_o == $past(timer3_value_i))
    else $error("capture value wrong");
  cap2_value_a: assert property (capture2_strobe_o |-> capture2_value_o == $past(timer3_value_i))
    else $error("capture2 value wrong");
  cas_pair_a: assert property (cascade_o |-> timer2_tick_o == timer1_tick_o)
    else $error("cascade tick mismatch");
endmodule
bind timer_capture_control tcc_checker u_tcc_checker (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .dat_o,
  .cascade_o, .timer1_tick_o, .timer2_tick_o, .capture2_strobe_o, .capture2_value_o, .timer3_tick_o,
  .capture1_strobe_o, .capture1_value_o, .timer3_value_i);
`default_nettype wire

// ---- tcc_pins.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far-side pins: t3 clock, shared clock, cap1, cap2; idle high
module tcc_pins
(
  input  wire logic       clk_i, // Clock
  output logic      [3:0] pin_o  // Pin levels
);
  initial pin_o = 4'hf;
  // N full periods, each level held 3 clocks
  task automatic wave(input int k, input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge clk_i);
      pin_o[k] <= ~pin_o[k];
    end
  endtask
endmodule
`default_nettype wire

// ---- timer_capture_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defs.svh"
module timer_capture_control_test;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, run, cas;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, pin;
  logic [31:0] dat_i, dat_o, rdat;
  logic [15:0] t3v;
  wire logic [4:0] p;
  int          cnt [5], b [5], e;
  int          failures, check_count;

  timer_capture_control u_timer_capture_control (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .timer3_ext_clock_pin_i(pin[0]), .shared_ext_clock_pin_i(pin[1]), .capture1_pin_i(pin[2]),
    .capture2_pin_i(pin[3]), .timer2_run_i(run), .timer3_value_i(t3v), .timer1_tick_o(p[0]),
    .timer2_tick_o(p[1]), .timer3_tick_o(p[2]), .cascade_o(cas), .capture1_strobe_o(p[3]),
    .capture2_strobe_o(p[4]), .capture1_value_o(), .capture2_value_o());
  tcc_pins u_tcc_pins (.clk_i, .pin_o(pin));

  initial
  begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Live timer3 count and pulse tallies
  always @(posedge clk_i) t3v <= t3v + 16'h1;
  always @(negedge clk_i) for (int k = 0; k < 5; k++) cnt[k] += int'(p[k]);

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // One classic cycle, held until ack
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'h1, 24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic close_out;
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, run, adr_i, sel_i, dat_i, t3v} = {1'b1, 64'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    xfer(`TCC_CTRL_ADDR, 0, 8'h0); chk(rdat, 32'h0);
    xfer(8'h44, 1, 8'hff); xfer(8'h44, 0, 8'h0); chk(rdat, 32'h0);
    // Every capture edge mode on both channels
    for (int m = 0; m < 4; m++)
    begin
      xfer(`TCC_CTRL_ADDR, 1, 8'({2'(m), 2'(m), 4'h0}));
      xfer(`TCC_CTRL_ADDR, 0, 8'h0); chk(rdat, 32'({2'(m), 2'(m), 4'h0}));
      b = cnt;
      fork u_tcc_pins.wave(2, 16); u_tcc_pins.wave(3, 16); join
      repeat (8) @(posedge clk_i);
      e = m < 2 ? 16 : (m == 2 ? 4 : 1);
      chk(cnt[3] - b[3], e);
      chk(cnt[4] - b[4], e);
    end
    // External sources, cascaded; timer2 follows timer1 though its own select is clear
    run <= 1;
    xfer(`TCC_CTRL_ADDR, 1, 8'h0d); repeat (8) @(posedge clk_i); b = cnt;
    chk(cas, 1);
    fork u_tcc_pins.wave(0, 5); u_tcc_pins.wave(1, 5); join
    repeat (8) @(posedge clk_i);
    chk(cnt[0] - b[0], 5);
    chk(cnt[1] - b[1], 5);
    chk(cnt[2] - b[2], 5);
    xfer(`TCC_STATUS_ADDR, 0, 8'h0); chk(rdat, 32'h3);
    run <= 0;
    xfer(`TCC_STATUS_ADDR, 0, 8'h0); chk(rdat, 32'h6);
    // Internal source: one tick per four clocks; timer2 on the shared pin
    xfer(`TCC_CTRL_ADDR, 1, 8'h02); repeat (8) @(posedge clk_i); b = cnt;
    fork repeat (40) @(posedge clk_i); u_tcc_pins.wave(1, 5); join
    chk(cnt[0] - b[0], 10);
    chk(cnt[1] - b[1], 5);
    chk(cnt[2] - b[2], 10);
    chk(cas, 0);
    close_out;
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk_i);
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
